// ===== core/qtcp_timer.sv
`timescale 1ns/1ps
// Four eight-bit timer/counters with pairing, capture, compare and PWM.
module qtcp_timer
    import qtcp_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          sys_rst,
    input  wire qtcp_apb_req_s apbReq,
    output qtcp_apb_rsp_s      apbRsp,
    input  wire logic [1:0]    eventPin,
    input  wire logic [3:0]    captureEdgePin,
    output logic               pulsePin,
    output logic [3:0]         matchFlag,
    output logic [3:0]         captureFlag
);
    typedef struct packed {
        logic [3:0][7:0] mode;
        logic [3:0][7:0] matchData;
        logic [3:0][7:0] cnt;
        logic [3:0][7:0] captureData;
        logic [7:0]      pulsePeriodLow;
        logic [7:0]      pulseDutyLow;
        logic [7:0]      pulseHighBits;
        logic [7:0]      edgeSelect;
        logic [7:0]      portFunction;
        logic [3:0]      matchFl;
        logic [3:0]      capFl;
        logic [11:0]     presc;
        logic [1:0]      evS1;
        logic [1:0]      evS2;
        logic [1:0]      evS3;
        logic [3:0]      cpS1;
        logic [3:0]      cpS2;
        logic [3:0]      cpS3;
        logic            cmpOut;
        logic            pin;
        qtcp_apb_rsp_s   rsp;
    } qtcp_state_s;

    qtcp_state_s st_reg;
    qtcp_state_s st_next;
    logic [3:0]  tick;
    logic [3:0]  hit;
    logic [3:0]  capEdge;
    logic [11:0] prescInc;
    logic        pwmOut;
    logic        pwmRun;

    assign prescInc = st_reg.presc + 12'h001;

    // Per-timer clock selection; prescaler carries become one-cycle ticks.
    always_comb begin
        logic [2:0] s;
        logic [1:0] e;
        s = 3'h0;
        e = 2'h0;
        for (int i = 0; i < 4; i += 2) begin
            s = st_reg.mode[i][4:2];
            e[i/2] = st_reg.evS2[i/2] & ~st_reg.evS3[i/2];
            unique case (s)
                3'h0: tick[i] = prescInc[0] & ~st_reg.presc[0];
                3'h1: tick[i] = &st_reg.presc[1:0];
                3'h2: tick[i] = &st_reg.presc[2:0];
                3'h3: tick[i] = &st_reg.presc[4:0];
                3'h4: tick[i] = &st_reg.presc[6:0];
                3'h5: tick[i] = &st_reg.presc[8:0];
                3'h6: tick[i] = &st_reg.presc[10:0];
                3'h7: tick[i] = e[i/2];
            endcase
        end
        for (int i = 1; i < 4; i += 2) begin
            unique case (st_reg.mode[i][3:2])
                2'h0: tick[i] = 1'b1;
                2'h1: tick[i] = st_reg.presc[0];
                2'h2: tick[i] = &st_reg.presc[2:0];
                2'h3: tick[i] = tick[i-1];
            endcase
        end
    end

    // Capture edge detection from the synchronised pins.
    generate
        for (genvar g = 0; g < 4; g++) begin : g_edge
            logic rise;
            logic fall;
            logic [1:0] sel;
            assign rise = st_reg.cpS2[g] & ~st_reg.cpS3[g];
            assign fall = ~st_reg.cpS2[g] & st_reg.cpS3[g];
            assign sel  = st_reg.edgeSelect[2*g +: 2];
            assign capEdge[g] = (sel == EDGE_FALL) ? fall :
                                (sel == EDGE_RISE) ? rise :
                                (sel == EDGE_BOTH) ? (rise | fall) : 1'b0;
        end
    endgenerate

    assign pwmRun = st_reg.mode[3][BIT_PEN] & st_reg.portFunction[BIT_PFUNC]
                    & st_reg.mode[3][BIT_START];

    always_comb begin
        logic        pair;
        logic        apbWr;
        logic        apbRd;
        logic [31:0] rd;
        logic [15:0] c16;
        int          ev;
        int          od;
        st_next = st_reg;
        ev = 0;
        od = 0;
        hit = 4'h0;
        apbWr = apbReq.psel & apbReq.penable & apbReq.pwrite;
        apbRd = apbReq.psel & apbReq.penable & ~apbReq.pwrite;
        rd = 32'h0;
        c16 = 16'h0;
        pair = 1'b0;
        st_next.presc = prescInc;
        st_next.evS1 = eventPin;
        st_next.evS2 = st_reg.evS1;
        st_next.evS3 = st_reg.evS2;
        st_next.cpS1 = captureEdgePin;
        st_next.cpS2 = st_reg.cpS1;
        st_next.cpS3 = st_reg.cpS2;
        for (int p = 0; p < 2; p++) begin
            ev = 2 * p;
            od = 2 * p + 1;
            pair = st_reg.mode[od][BIT_PAIR];
            if (pair) begin
                c16 = {st_reg.cnt[od], st_reg.cnt[ev]};
                if (capEdge[ev] && st_reg.mode[ev][BIT_CAP]) begin
                    st_next.captureData[ev] = st_reg.cnt[ev];
                    st_next.captureData[od] = st_reg.cnt[od];
                    st_next.cnt[ev] = 8'h00;
                    st_next.cnt[od] = 8'h00;
                end else if (st_reg.mode[ev][BIT_START] && tick[ev]) begin
                    if (c16 == {st_reg.matchData[od],
                                st_reg.matchData[ev]}) begin
                        hit[ev] = 1'b1;
                        c16 = 16'h0000;
                    end else begin
                        c16 = c16 + 16'h0001;
                    end
                    st_next.cnt[ev] = c16[7:0];
                    st_next.cnt[od] = c16[15:8];
                end
            end else begin
                for (int k = ev; k <= od; k++) begin
                    if (capEdge[k] && st_reg.mode[k][BIT_CAP]) begin
                        st_next.captureData[k] = st_reg.cnt[k];
                        st_next.cnt[k] = 8'h00;
                    end else if (st_reg.mode[k][BIT_START] && tick[k]
                                 && !(k == 3 && pwmRun)) begin
                        if (st_reg.cnt[k] == st_reg.matchData[k]) begin
                            hit[k] = 1'b1;
                            st_next.cnt[k] = 8'h00;
                        end else begin
                            st_next.cnt[k] = st_reg.cnt[k] + 8'h01;
                        end
                    end
                end
            end
        end
        for (int k = 0; k < 4; k++) begin
            if (!st_reg.mode[k][BIT_START] && !st_reg.mode[k][BIT_CONT]) begin
                st_next.cnt[k] = 8'h00;
            end
        end
        // Compare toggles on timer two's match while PWM is off.
        if (hit[2] && !st_reg.mode[3][BIT_PEN]) begin
            st_next.cmpOut = ~st_reg.cmpOut;
        end
        if (!st_reg.portFunction[BIT_PFUNC]) begin
            st_next.pin = 1'b0;
        end else if (st_reg.mode[3][BIT_PEN]) begin
            st_next.pin = pwmOut;
        end else begin
            st_next.pin = st_reg.cmpOut;
        end
        for (int k = 0; k < 4; k++) begin
            unique case (apbReq.paddr)
                ADDR_DATA0 + 12'(4 * k): begin
                    rd = st_reg.mode[k][BIT_CAP] ? {24'h0, st_reg.captureData[k]}
                                                 : {24'h0, st_reg.cnt[k]};
                end
                ADDR_MODE0 + 12'(4 * k): rd = {24'h0, st_reg.mode[k]};
                default: ;
            endcase
        end
        unique case (apbReq.paddr)
            ADDR_PPER:  rd = {24'h0, st_reg.pulsePeriodLow};
            ADDR_PDUTY: rd = {24'h0, st_reg.pulseDutyLow};
            ADDR_PHIGH: rd = {24'h0, st_reg.pulseHighBits};
            ADDR_EDGE:  rd = {24'h0, st_reg.edgeSelect};
            ADDR_FUNC:  rd = {24'h0, st_reg.portFunction};
            ADDR_FLAGS: rd = {24'h0, st_reg.capFl, st_reg.matchFl};
            default: ;
        endcase
        // Hardware set wins over a software clear in the same cycle.
        st_next.matchFl = st_reg.matchFl;
        st_next.capFl = st_reg.capFl;
        if (apbWr && apbReq.paddr == ADDR_FLAGS) begin
            st_next.matchFl = st_reg.matchFl & ~apbReq.pwdata[3:0];
            st_next.capFl = st_reg.capFl & ~apbReq.pwdata[7:4];
        end
        st_next.matchFl = st_next.matchFl | (hit & 4'h5)
                          | (hit & 4'ha & ~{st_reg.mode[3][BIT_PAIR], 1'b0,
                                            st_reg.mode[1][BIT_PAIR], 1'b0});
        st_next.capFl = st_next.capFl | (capEdge & {st_reg.mode[3][BIT_CAP],
            st_reg.mode[2][BIT_CAP], st_reg.mode[1][BIT_CAP],
            st_reg.mode[0][BIT_CAP]});
        if (apbWr) begin
            for (int k = 0; k < 4; k++) begin
                if (apbReq.paddr == ADDR_MODE0 + 12'(4 * k)) begin
                    st_next.mode[k] = apbReq.pwdata[7:0];
                end
                if (apbReq.paddr == ADDR_DATA0 + 12'(4 * k)) begin
                    st_next.matchData[k] = apbReq.pwdata[7:0];
                end
            end
            unique case (apbReq.paddr)
                ADDR_PPER:  st_next.pulsePeriodLow = apbReq.pwdata[7:0];
                ADDR_PDUTY: st_next.pulseDutyLow = apbReq.pwdata[7:0];
                ADDR_PHIGH: st_next.pulseHighBits = {4'h0, apbReq.pwdata[3:0]};
                ADDR_EDGE:  st_next.edgeSelect = apbReq.pwdata[7:0];
                ADDR_FUNC:  st_next.portFunction = apbReq.pwdata[7:0];
                default: ;
            endcase
        end
        st_next.rsp.pready = apbReq.psel & apbReq.penable & ~st_reg.rsp.pready;
        st_next.rsp.prdata = apbRd ? rd : 32'h0;
        st_next.rsp.pslverr = 1'b0;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.matchData <= {4{DATA_RESET}};
        end else begin
            st_reg <= st_next;
        end
    end

    qtcp_pwm_unit u_pwm (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .tick     (tick[3]),
        .run      (pwmRun),
        .period   ({st_reg.pulseHighBits[3:2], st_reg.pulsePeriodLow}),
        .duty     ({st_reg.pulseHighBits[1:0], st_reg.pulseDutyLow}),
        .polarity (st_reg.mode[3][BIT_POL]),
        .pwmOut   (pwmOut)
    );

    assign apbRsp      = st_reg.rsp;
    assign pulsePin    = st_reg.pin;
    assign matchFlag   = st_reg.matchFl;
    assign captureFlag = st_reg.capFl;

    a_match_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
        hit[0] && !st_reg.mode[1][BIT_PAIR] && !capEdge[0]
        |=> st_reg.cnt[0] == 8'h00 && st_reg.matchFl[0])
        else $error("match did not clear count and set flag");
    a_pair_odd_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st_reg.mode[1][BIT_PAIR] && !$past(st_reg.matchFl[1]) && !st_reg.matchFl[1]
        && !(apbReq.psel && apbReq.paddr == ADDR_FLAGS) |=> !st_reg.matchFl[1])
        else $error("odd flag raised in paired mode");
    a_capture_copy: assert property (@(posedge sys_clk) disable iff (sys_rst)
        capEdge[2] && st_reg.mode[2][BIT_CAP] && !st_reg.mode[3][BIT_PAIR]
        |=> st_reg.captureData[2] == $past(st_reg.cnt[2])
            && st_reg.cnt[2] == 8'h00 && st_reg.capFl[2])
        else $error("capture did not copy and clear");
    a_odd_prescale: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st_reg.mode[1][3:2] == 2'h2 |-> tick[1] == (st_reg.presc[2:0] == 3'h7))
        else $error("odd timer divide by eight wrong");
    a_compare_toggle: assert property (@(posedge sys_clk) disable iff (sys_rst)
        hit[2] && !st_reg.mode[3][BIT_PEN] |=> st_reg.cmpOut != $past(st_reg.cmpOut))
        else $error("compare output did not toggle");
    a_shared_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        apbReq.psel && apbReq.penable && !apbReq.pwrite
        && apbReq.paddr == ADDR_DATA0 && !st_reg.rsp.pready && !st_reg.mode[0][BIT_CAP]
        |=> apbRsp.pready && apbRsp.prdata[7:0] == $past(st_reg.cnt[0]))
        else $error("shared read returned wrong value");

    // Clock selection, counting, capture, pin routing and match data write checks.
    a_even_prescale: assert property (@(posedge sys_clk)
        disable iff (sys_rst) st_reg.mode[2][4:2] == 3'h3
        |-> tick[2] == (st_reg.presc[4:0] == 5'h1f))
        else $error("even timer divide by 32 wrong");
    a_odd_borrow: assert property (@(posedge sys_clk)
        disable iff (sys_rst) st_reg.mode[1][3:2] == 2'h3
        |-> tick[1] == tick[0])
        else $error("odd timer did not borrow even clock");
    a_event_tick: assert property (@(posedge sys_clk)
        disable iff (sys_rst) st_reg.mode[0][4:2] == CK_EXTERNAL
        |-> tick[0] == (st_reg.evS2[0] && !st_reg.evS3[0]))
        else $error("event counter tick not on rising edge");
    a_count_step: assert property (@(posedge sys_clk)
        disable iff (sys_rst) st_reg.mode[0][BIT_START] && tick[0] && !hit[0]
        && !st_reg.mode[1][BIT_PAIR] && !st_reg.mode[0][BIT_CAP]
        |=> st_reg.cnt[0] == $past(st_reg.cnt[0]) + 8'h01)
        else $error("count did not step by one");
    a_pair_wrap: assert property (@(posedge sys_clk)
        disable iff (sys_rst) st_reg.mode[1][BIT_PAIR] && hit[0]
        |=> {st_reg.cnt[1], st_reg.cnt[0]} == 16'h0000 && st_reg.matchFl[0])
        else $error("paired counter did not wrap with even flag");
    a_capture_match: assert property (@(posedge sys_clk)
        disable iff (sys_rst) st_reg.mode[2][BIT_CAP] && hit[2]
        |=> st_reg.matchFl[2])
        else $error("match flag lost in capture mode");
    a_edge_rise: assert property (@(posedge sys_clk)
        disable iff (sys_rst) st_reg.edgeSelect[5:4] == EDGE_RISE
        |-> capEdge[2] == (st_reg.cpS2[2] && !st_reg.cpS3[2]))
        else $error("rising capture edge not selected");
    a_pwm_pin: assert property (@(posedge sys_clk)
        disable iff (sys_rst) pwmRun
        |=> pulsePin == $past(pwmOut))
        else $error("pulse pin did not follow pulse output");
    a_data_write: assert property (@(posedge sys_clk)
        disable iff (sys_rst) apbReq.psel && apbReq.penable && apbReq.pwrite
        && apbReq.paddr == ADDR_DATA0
        |=> st_reg.matchData[0] == $past(apbReq.pwdata[7:0]))
        else $error("match data write not applied");
endmodule : qtcp_timer

// ===== core/qtcp_pkg.sv
// Package with register map, field positions and shared types of the timer block.
package qtcp_pkg;

    localparam logic [11:0] ADDR_MODE0   = 12'h000;
    localparam logic [11:0] ADDR_MODE1   = 12'h004;
    localparam logic [11:0] ADDR_MODE2   = 12'h008;
    localparam logic [11:0] ADDR_MODE3   = 12'h00c;
    localparam logic [11:0] ADDR_DATA0   = 12'h010;
    localparam logic [11:0] ADDR_DATA1   = 12'h014;
    localparam logic [11:0] ADDR_DATA2   = 12'h018;
    localparam logic [11:0] ADDR_DATA3   = 12'h01c;
    localparam logic [11:0] ADDR_PPER    = 12'h020;
    localparam logic [11:0] ADDR_PDUTY   = 12'h024;
    localparam logic [11:0] ADDR_PHIGH   = 12'h028;
    localparam logic [11:0] ADDR_EDGE    = 12'h02c;
    localparam logic [11:0] ADDR_FUNC    = 12'h030;
    localparam logic [11:0] ADDR_FLAGS   = 12'h034;

    localparam int BIT_START  = 0;
    localparam int BIT_CONT   = 1;
    localparam int BIT_CAP    = 5;
    localparam int BIT_PAIR   = 6;
    localparam int BIT_PEN    = 5;
    localparam int BIT_POL    = 7;
    localparam int BIT_PFUNC  = 0;

    localparam logic [2:0] CK_EXTERNAL = 3'h7;
    localparam logic [1:0] CK_BORROW   = 2'h3;
    localparam logic [7:0] MODE_RESET  = 8'h00;
    localparam logic [7:0] DATA_RESET  = 8'hff;
    localparam logic [11:0] PRESC_RESET = 12'h000;

    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } qtcp_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } qtcp_apb_rsp_s;

endpackage : qtcp_pkg

// ===== core/qtcp_pwm_unit.sv
`timescale 1ns/1ps
// Ten-bit pulse generator with double-buffered duty for the fourth timer.
module qtcp_pwm_unit
    import qtcp_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       tick,
    input  wire logic       run,
    input  wire logic [9:0] period,
    input  wire logic [9:0] duty,
    input  wire logic       polarity,
    output logic            pwmOut
);
    typedef struct packed {
        logic [9:0] cnt;
        logic [9:0] activeDuty;
        logic       out;
    } qtcp_pwm_s;

    qtcp_pwm_s st_reg;
    qtcp_pwm_s st_next;

    always_comb begin
        st_next = st_reg;
        if (!run) begin
            st_next.cnt = 10'h000;
            st_next.activeDuty = duty;
        end else if (tick) begin
            if (st_reg.cnt == period) begin
                st_next.cnt = 10'h000;
                st_next.activeDuty = duty;
            end else begin
                st_next.cnt = st_reg.cnt + 10'h001;
            end
        end
        // Duty portion first; equal duty and period keeps the duty level.
        if (st_next.activeDuty == 10'h000) begin
            st_next.out = ~polarity;
        end else if (st_next.activeDuty >= period) begin
            st_next.out = polarity;
        end else begin
            st_next.out = (st_next.cnt < st_next.activeDuty) ? polarity
                                                             : ~polarity;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pwmOut = st_reg.out;

    a_pwm_zero_duty: assert property (@(posedge sys_clk) disable iff (sys_rst)
        run && st_reg.activeDuty == 10'h000 && duty == 10'h000
        |-> ##1 pwmOut == $past(~polarity))
        else $error("zero duty did not hold inverse level");
    a_pwm_buffer: assert property (@(posedge sys_clk) disable iff (sys_rst)
        run && tick && st_reg.cnt != period |=> $stable(st_reg.activeDuty))
        else $error("active duty changed mid period");
endmodule : qtcp_pwm_unit

// ===== verification/qtcp_pin_model.sv
// Pin-side model that drives the event and capture inputs of the timer block.
`timescale 1ns/1ps
module qtcp_pin_model
    import qtcp_pkg::*;
(
    input  wire logic sys_clk,
    output logic [1:0] eventPin,
    output logic [3:0] captureEdgePin
);
    initial begin
        eventPin = 2'h0;
        captureEdgePin = 4'h0;
    end

    // Each level is held for gap clocks so the input synchroniser sees it.
    task automatic pulse(input int idx, input int cnt, input int gap);
        for (int i = 0; i < cnt; i++) begin
            @(posedge sys_clk);
            eventPin[idx] <= 1'b1;
            repeat (gap) @(posedge sys_clk);
            eventPin[idx] <= 1'b0;
            repeat (gap) @(posedge sys_clk);
        end
        repeat (4) @(posedge sys_clk);
    endtask : pulse

    task automatic cap(input int idx, input logic lvl);
        @(posedge sys_clk);
        captureEdgePin[idx] <= lvl;
        repeat (6) @(posedge sys_clk);
    endtask : cap
endmodule : qtcp_pin_model

// ===== verification/quad_timer_capture_pwm_bench.sv
// Self-checking bench for the quad timer with capture and pulse output.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    cmpCount++; \
    if ((got) !== (exp)) begin \
        errorCnt++; \
        $display("BAD t=%0t got %h exp %h", $time, got, exp); \
    end \
end
module quad_timer_capture_pwm_bench
    import qtcp_pkg::*;
;
    logic          sys_clk = 1'b0;
    logic          sys_rst = 1'b1;
    qtcp_apb_req_s apbReq = '0;
    qtcp_apb_rsp_s apbRsp;
    logic [1:0]    eventPin;
    logic [3:0]    captureEdgePin;
    logic          pulsePin;
    logic [3:0]    matchFlag;
    logic [3:0]    captureFlag;
    logic [31:0]   seed = 32'he2d36871;
    int            errorCnt = 0;
    int            cmpCount = 0;
    int            cycles = 0;
    int            n;
    int            g;
    int            p;
    logic [31:0]   rdVal;

    qtcp_timer qtcp_timer_inst (
        .sys_clk        (sys_clk),
        .sys_rst        (sys_rst),
        .apbReq         (apbReq),
        .apbRsp         (apbRsp),
        .eventPin       (eventPin),
        .captureEdgePin (captureEdgePin),
        .pulsePin       (pulsePin),
        .matchFlag      (matchFlag),
        .captureFlag    (captureFlag)
    );
    qtcp_pin_model qtcp_pin_model_inst (
        .sys_clk        (sys_clk),
        .eventPin       (eventPin),
        .captureEdgePin (captureEdgePin)
    );

    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 70000) begin
            errorCnt++;
            results();
        end
    end

    task results;
        if (errorCnt == 0 && cmpCount > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic int evenDiv(input int c);
        return (c < 3) ? (2 << c) : (8 << (2 * (c - 2)));
    endfunction : evenDiv

    function automatic int oddDiv(input int c);
        return (c == 0) ? 1 : ((c == 1) ? 2 : 8);
    endfunction : oddDiv

    task apb(input logic wrt, input logic [11:0] adr, input logic [31:0] dat,
             output logic [31:0] q);
        @(posedge sys_clk);
        apbReq.paddr   <= adr;
        apbReq.pwrite  <= wrt;
        apbReq.pwdata  <= dat;
        apbReq.psel    <= 1'b1;
        apbReq.penable <= 1'b0;
        @(posedge sys_clk);
        apbReq.penable <= 1'b1;
        do @(posedge sys_clk); while (apbRsp.pready !== 1'b1);
        q = apbRsp.prdata;
        apbReq.psel    <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] adr, input logic [31:0] dat);
        logic [31:0] q;
        apb(1'b1, adr, dat, q);
    endtask : wr

    task rd(input logic [11:0] adr, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, adr, 32'h0, q);
        `CHK(q, exp)
        `CHK(apbRsp.pslverr, 1'b0)
    endtask : rd

    task ev(input int idx, input int cnt);
        qtcp_pin_model_inst.pulse(idx, cnt, int'(xs() % 32'd4) + 2);
    endtask : ev

    // Counts clocks over the given number of pin changes after one change.
    task gaps(input int changes, output int len);
        logic lv;
        lv = pulsePin;
        len = 0;
        do @(posedge sys_clk); while (pulsePin === lv);
        for (int i = 0; i < changes; i++) begin
            lv = pulsePin;
            do begin
                @(posedge sys_clk);
                len++;
            end while (pulsePin === lv);
        end
    endtask : gaps

    task highs(input int len, output int h);
        h = 0;
        repeat (len) begin
            @(posedge sys_clk);
            h += int'(pulsePin === 1'b1);
        end
    endtask : highs

    task pwm(input int per, input int dut, input logic [7:0] ctl);
        wr(ADDR_MODE3, 32'h0);
        wr(ADDR_PPER, 32'(per[7:0]));
        wr(ADDR_PDUTY, 32'(dut[7:0]));
        wr(ADDR_PHIGH, 32'({per[9:8], dut[9:8]}));
        wr(ADDR_MODE3, 32'(ctl));
    endtask : pwm

    initial begin
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 4; i++)
            rd(ADDR_MODE0 + 12'(4 * i), 32'(MODE_RESET));
        rd(ADDR_FLAGS, 32'h0);
        wr(12'h03c, 32'h5a);
        rd(12'h03c, 32'h0);
        `CHK(pulsePin, 1'b0)
        for (int t = 0; t < 2; t++) begin
            n = int'(xs() % 32'd20) + 1;
            wr(ADDR_MODE0 + 12'(8 * t), 32'h1d);
            ev(t, n);
            rd(ADDR_DATA0 + 12'(8 * t), 32'(n));
        end
        wr(ADDR_MODE0, 32'h0);
        n = int'(xs() % 32'd15) + 2;
        wr(ADDR_DATA0, 32'(n));
        wr(ADDR_MODE0, 32'h1d);
        ev(0, n);
        `CHK(matchFlag, 4'h0)
        rd(ADDR_DATA0, 32'(n));
        ev(0, 1);
        `CHK(matchFlag, 4'h1)
        rd(ADDR_DATA0, 32'h0);
        wr(ADDR_FLAGS, 32'hff);
        rd(ADDR_FLAGS, 32'h0);
        wr(ADDR_MODE0, 32'h0);
        wr(ADDR_DATA0, 32'h02);
        wr(ADDR_DATA1, 32'h01);
        wr(ADDR_MODE1, 32'h4d);
        wr(ADDR_MODE0, 32'h1d);
        ev(0, 258);
        rd(ADDR_DATA0, 32'h02);
        rd(ADDR_DATA1, 32'h01);
        `CHK(matchFlag, 4'h0)
        ev(0, 1);
        `CHK(matchFlag, 4'h1)
        wr(ADDR_MODE1, 32'h0);
        wr(ADDR_DATA1, 32'hff);
        wr(ADDR_MODE1, 32'h09);
        repeat (80) @(posedge sys_clk);
        apb(1'b0, ADDR_DATA1, 32'h0, rdVal);
        `CHK(rdVal == 32'd10 || rdVal == 32'd11, 1'b1)
        wr(ADDR_MODE1, 32'h0);
        for (int m = 0; m < 3; m++) begin
            wr(ADDR_MODE2, 32'h0);
            wr(ADDR_EDGE, 32'(m) << 4);
            wr(ADDR_FLAGS, 32'hff);
            wr(ADDR_MODE2, 32'h3d);
            n = int'(xs() % 32'd10) + 1;
            ev(1, n);
            qtcp_pin_model_inst.cap(2, 1'b1);
            `CHK(captureFlag, {1'b0, m != 0, 2'b00})
            if (m != 0)
                rd(ADDR_DATA2, 32'(n));
            wr(ADDR_FLAGS, 32'hff);
            qtcp_pin_model_inst.cap(2, 1'b0);
            `CHK(captureFlag, {1'b0, m != 1, 2'b00})
            rd(ADDR_DATA2, (m == 2) ? 32'h0 : 32'(n));
        end
        wr(ADDR_MODE2, 32'h0);
        wr(ADDR_DATA2, 32'h3);
        wr(ADDR_MODE2, 32'h3d);
        wr(ADDR_FLAGS, 32'hff);
        ev(1, 4);
        `CHK(matchFlag, 4'h4)
        wr(ADDR_MODE2, 32'h0);
        wr(ADDR_DATA2, 32'h1);
        wr(ADDR_FUNC, 32'h1);
        for (int c = 0; c < 7; c++) begin
            wr(ADDR_MODE2, 32'(c << 2 | 1));
            gaps(1, g);
            gaps(1, g);
            `CHK(g, 2 * evenDiv(c))
        end
        wr(ADDR_MODE2, 32'h0);
        for (int c = 0; c < 3; c++) begin
            p = 256 + int'(xs() % 32'd64);
            pwm(p, p / 2, 8'h21 | 8'(c << 2));
            gaps(2, g);
            gaps(2, g);
            `CHK(g, (p + 1) * oddDiv(c))
        end
        for (int pol = 0; pol < 2; pol++) begin
            pwm(40, 4, 8'h21 | 8'(pol << 7));
            gaps(2, g);
            highs(41, g);
            `CHK(g * 2 < 41, pol == 1)
            pwm(40, 40, 8'h21 | 8'(pol << 7));
            repeat (90) @(posedge sys_clk);
            highs(123, g);
            `CHK(g, (pol == 1) ? 123 : 0)
            pwm(40, 0, 8'h21 | 8'(pol << 7));
            repeat (90) @(posedge sys_clk);
            highs(123, g);
            `CHK(g, (pol == 1) ? 0 : 123)
        end
        results();
    end
endmodule : quad_timer_capture_pwm_bench
